// File: system_pin_map.svh
// System pin control: constant definitions.
// Assumes inclusion by bare name from the package and modules.
`ifndef SYSTEM_PIN_MAP_SVH
`define SYSTEM_PIN_MAP_SVH

`define MODE_WIDTH 3
`define MODE_NORMAL 3'h0
`define MODE_EEPROM 3'h1
`define DOWNSTREAM_PORTS 3
`define FUND_RESET_NS 1000
`define CLK_PERIOD_NS 100
`define FUND_RESET_CYCLES ((`FUND_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COUNT_WIDTH 4
`define SYNC_RESET_VALUE 1'h0

`endif

// File: system_pin_pkg.sv
// System pin control: shared types.
// Assumes system_pin_map.svh is on the include path.
`include "system_pin_map.svh"

package system_pin_pkg;

   typedef enum logic [3:0]
   {
      st_reset = 4'h1,
      st_init = 4'h2,
      st_halt = 4'h4,
      st_run = 4'h8
   } seq_state_t;

   typedef logic [`MODE_WIDTH-1:0] switch_mode_t;

endpackage : system_pin_pkg

// File: pin_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`include "system_pin_map.svh"

module pin_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync;

   always_comb
   begin
      next_stage1 = async_i;
      next_sync = stage1;
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         stage1 <= {WIDTH{`SYNC_RESET_VALUE}};
         sync_o <= {WIDTH{`SYNC_RESET_VALUE}};
      end
      else
      begin
         stage1 <= next_stage1;
         sync_o <= next_sync;
      end
   end

endmodule : pin_sync

// File: system_pin_reset_config.sv
// System pin control: fundamental reset, halt, straps, wake pin, aux power.
// Assumes board straps are stable around the release of fundamental reset
// and that the management master writes the control bits as plain ports.
//
// Behaviour
// - Names ending N are active low
// - Aux power disable blocks aux supply use
// - Downstream strap presets downstream slot clock bits
// - Software write replaces downstream slot clock
// - Upstream strap presets upstream slot clock bit
// - Software write replaces upstream slot clock
// - Fundamental reset resets logic, starts link reset
// - Hold request keeps reset, serial master running
// - Clearing hold bit releases reset, normal run
// - Mode 0 normal, 1 EEPROM init, rest reserved
// - Direction bit selects wake pin in/out
`timescale 1ns/1ps
`include "system_pin_map.svh"

module system_pin_reset_config
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic fundamental_reset_n_i,
   input wire logic reset_hold_request_i,
   input wire logic [`MODE_WIDTH-1:0] switch_mode_strap_i,
   input wire logic common_clock_upstream_strap_i,
   input wire logic common_clock_downstream_strap_i,
   input wire logic aux_power_disable_n_i,
   input wire logic wake_pin_n_i,
   input wire logic wake_direction_bit_i,
   input wire logic wake_request_i,
   input wire logic hold_bit_clear_i,
   input wire logic up_slot_clock_write_i,
   input wire logic up_slot_clock_data_i,
   input wire logic [`DOWNSTREAM_PORTS-1:0] down_slot_clock_write_i,
   input wire logic [`DOWNSTREAM_PORTS-1:0] down_slot_clock_data_i,
   output logic core_reset_n_o,
   output logic link_reset_o,
   output logic serial_master_enable_o,
   output logic switch_run_o,
   output logic eeprom_init_o,
   output logic mode_reserved_o,
   output logic hold_bit_o,
   output logic up_slot_clock_o,
   output logic [`DOWNSTREAM_PORTS-1:0] down_slot_clock_o,
   output logic aux_power_enable_o,
   output logic wake_pin_n_o,
   output logic wake_pin_n_oe_o,
   output logic wake_detected_o
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   localparam int SYNC_W = `MODE_WIDTH + 6;
   logic [SYNC_W-1:0] pins_async;
   logic [SYNC_W-1:0] pins_sync;
   logic fund_rst_n;
   logic hold_req;
   logic [`MODE_WIDTH-1:0] mode_pin;
   logic up_strap;
   logic down_strap;
   logic aux_dis_n;
   logic wake_seen;

   // Wake level inverted so the cleared flops read as idle pin
   assign pins_async = {fundamental_reset_n_i, reset_hold_request_i,
      switch_mode_strap_i, common_clock_upstream_strap_i,
      common_clock_downstream_strap_i, aux_power_disable_n_i,
      !wake_pin_n_i};

   pin_sync #(.WIDTH(SYNC_W)) u_sync
   (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .async_i(pins_async),
      .sync_o(pins_sync)
   );

   assign {fund_rst_n, hold_req, mode_pin, up_strap, down_strap,
      aux_dis_n, wake_seen} = pins_sync;

   ////////////////////////////////////////////////////////////////////////
   // Reset sequencer
   system_pin_pkg::seq_state_t state;
   system_pin_pkg::seq_state_t next_state;
   logic [`COUNT_WIDTH-1:0] count;
   logic [`COUNT_WIDTH-1:0] next_count;
   logic hold;
   logic next_hold;
   system_pin_pkg::switch_mode_t mode;
   system_pin_pkg::switch_mode_t next_mode;
   logic up_slot;
   logic next_up_slot;
   logic [`DOWNSTREAM_PORTS-1:0] down_slot;
   logic [`DOWNSTREAM_PORTS-1:0] next_down_slot;

   always_comb
   begin
      next_state = state;
      next_count = count;
      next_hold = hold;
      next_mode = mode;
      next_up_slot = up_slot;
      next_down_slot = down_slot;
      if (!fund_rst_n)
      begin
         next_state = system_pin_pkg::st_reset;
         next_count = '0;
         next_hold = 1'b0;
      end
      else
      begin
         case (state)
            system_pin_pkg::st_reset:
            begin
               next_state = system_pin_pkg::st_init;
               next_count = '0;
               next_mode = mode_pin;
               next_up_slot = up_strap;
               next_down_slot = {`DOWNSTREAM_PORTS{down_strap}};
               next_hold = hold_req;
            end
            system_pin_pkg::st_init:
            begin
               if (count >= `COUNT_WIDTH'(`FUND_RESET_CYCLES - 1))
               begin
                  next_state = hold ? system_pin_pkg::st_halt
                     : system_pin_pkg::st_run;
               end
               else
               begin
                  next_count = count + `COUNT_WIDTH'(1);
               end
            end
            system_pin_pkg::st_halt:
            begin
               if (hold_bit_clear_i)
               begin
                  next_hold = 1'b0;
                  next_state = system_pin_pkg::st_run;
               end
            end
            system_pin_pkg::st_run:
            begin
               next_state = system_pin_pkg::st_run;
            end
            default:
            begin
               next_state = system_pin_pkg::st_reset;
            end
         endcase
         if (state != system_pin_pkg::st_reset)
         begin
            if (up_slot_clock_write_i)
            begin
               next_up_slot = up_slot_clock_data_i;
            end
            for (int i = 0; i < `DOWNSTREAM_PORTS; i++)
            begin
               if (down_slot_clock_write_i[i])
               begin
                  next_down_slot[i] = down_slot_clock_data_i[i];
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state <= system_pin_pkg::st_reset;
         count <= '0;
         hold <= 1'b0;
         mode <= `MODE_NORMAL;
         up_slot <= 1'b0;
         down_slot <= '0;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
         hold <= next_hold;
         mode <= next_mode;
         up_slot <= next_up_slot;
         down_slot <= next_down_slot;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   logic running;
   logic next_core_reset_n;
   logic next_link_reset;
   logic next_serial_master;
   logic next_run;
   logic next_eeprom;
   logic next_reserved;
   logic next_aux_en;
   logic next_wake_oe;
   logic next_wake_det;

   always_comb
   begin
      running = (next_state == system_pin_pkg::st_run);
      next_core_reset_n = running;
      next_link_reset = (next_state == system_pin_pkg::st_reset)
         || (next_state == system_pin_pkg::st_init);
      next_serial_master = (next_state == system_pin_pkg::st_halt)
         || running;
      next_run = running && (next_mode == `MODE_NORMAL
         || next_mode == `MODE_EEPROM);
      next_eeprom = (next_mode == `MODE_EEPROM)
         && (next_state != system_pin_pkg::st_reset);
      next_reserved = (next_mode != `MODE_NORMAL)
         && (next_mode != `MODE_EEPROM);
      next_aux_en = aux_dis_n;
      next_wake_oe = wake_direction_bit_i && wake_request_i;
      next_wake_det = !wake_direction_bit_i && wake_seen;
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         core_reset_n_o <= 1'b0;
         link_reset_o <= 1'b1;
         serial_master_enable_o <= 1'b0;
         switch_run_o <= 1'b0;
         eeprom_init_o <= 1'b0;
         mode_reserved_o <= 1'b0;
         hold_bit_o <= 1'b0;
         up_slot_clock_o <= 1'b0;
         down_slot_clock_o <= '0;
         aux_power_enable_o <= 1'b0;
         wake_pin_n_o <= 1'b0;
         wake_pin_n_oe_o <= 1'b0;
         wake_detected_o <= 1'b0;
      end
      else
      begin
         core_reset_n_o <= next_core_reset_n;
         link_reset_o <= next_link_reset;
         serial_master_enable_o <= next_serial_master;
         switch_run_o <= next_run;
         eeprom_init_o <= next_eeprom;
         mode_reserved_o <= next_reserved;
         hold_bit_o <= next_hold;
         up_slot_clock_o <= next_up_slot;
         down_slot_clock_o <= next_down_slot;
         aux_power_enable_o <= next_aux_en;
         wake_pin_n_o <= 1'b0;
         wake_pin_n_oe_o <= next_wake_oe;
         wake_detected_o <= next_wake_det;
      end
   end

endmodule : system_pin_reset_config

// File: pin_ctl_monitor.sv
// Checker for the system pin control block.
// Assumes binding onto the block's ports.
`timescale 1ns/1ps
module pin_ctl_monitor
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic fundamental_reset_n_i,
   input wire logic aux_power_disable_n_i,
   input wire logic common_clock_upstream_strap_i,
   input wire logic wake_direction_bit_i,
   input wire logic hold_bit_clear_i,
   input wire logic up_slot_clock_write_i,
   input wire logic up_slot_clock_data_i,
   input wire logic core_reset_n_o,
   input wire logic link_reset_o,
   input wire logic switch_run_o,
   input wire logic mode_reserved_o,
   input wire logic hold_bit_o,
   input wire logic up_slot_clock_o,
   input wire logic aux_power_enable_o,
   input wire logic wake_pin_n_oe_o
);
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);
   AST_FUND:
      assert property (!fundamental_reset_n_i [*4] |=>
         !core_reset_n_o && link_reset_o) else $error("reset");
   AST_HALT:
      assert property (hold_bit_o |-> !core_reset_n_o) else $error("halt");
   AST_CLR:
      assert property (hold_bit_o && hold_bit_clear_i |=>
         core_reset_n_o && !hold_bit_o) else $error("clear");
   AST_MODE:
      assert property (switch_run_o |-> !mode_reserved_o) else $error("mode");
   AST_AUX:
      assert property (!aux_power_disable_n_i [*4] |-> !aux_power_enable_o)
         else $error("aux");
   AST_WAKE:
      assert property (!wake_direction_bit_i && !$past(wake_direction_bit_i)
         |-> !wake_pin_n_oe_o) else $error("wake");
   AST_STRAP:
      assert property ($fell(link_reset_o) |->
         up_slot_clock_o == common_clock_upstream_strap_i) else $error("strap");
   AST_UPWR:
      assert property (core_reset_n_o && fundamental_reset_n_i &&
         up_slot_clock_write_i |=> up_slot_clock_o == $past(up_slot_clock_data_i))
         else $error("write");
endmodule : pin_ctl_monitor
bind system_pin_reset_config pin_ctl_monitor i_pin_ctl_monitor
(
   .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
   .fundamental_reset_n_i(fundamental_reset_n_i),
   .aux_power_disable_n_i(aux_power_disable_n_i),
   .common_clock_upstream_strap_i(common_clock_upstream_strap_i),
   .wake_direction_bit_i(wake_direction_bit_i),
   .hold_bit_clear_i(hold_bit_clear_i),
   .up_slot_clock_write_i(up_slot_clock_write_i),
   .up_slot_clock_data_i(up_slot_clock_data_i),
   .core_reset_n_o(core_reset_n_o), .link_reset_o(link_reset_o),
   .switch_run_o(switch_run_o), .mode_reserved_o(mode_reserved_o),
   .hold_bit_o(hold_bit_o), .up_slot_clock_o(up_slot_clock_o),
   .aux_power_enable_o(aux_power_enable_o),
   .wake_pin_n_oe_o(wake_pin_n_oe_o)
);

// File: board_partner.sv
// Board reset and strap logic with a management master.
// Assumes the bench calls boot to cycle the reset pin.
`timescale 1ns/1ps
module board_partner
(
   input wire logic clk_sys_i,
   input wire logic hold_bit_i,
   input wire logic master_on_i,
   input wire logic [7:0] delay_i,
   output logic fund_n_o,
   output logic hold_req_o,
   output logic [2:0] mode_o,
   output logic up_o,
   output logic dn_o,
   output logic clear_o
);
   logic [7:0] cnt = 8'h00;
   initial
      {fund_n_o, hold_req_o, mode_o, up_o, dn_o} = 7'h00;
   task automatic boot(input logic [2:0] m, input logic h, u, d);
      @(posedge clk_sys_i);
      fund_n_o <= 1'h0;
      {hold_req_o, mode_o, up_o, dn_o} <= {h, m, u, d};
      repeat (6) @(posedge clk_sys_i);
      fund_n_o <= 1'h1;
   endtask : boot
   // Clears the hold bit a chosen delay after the halt is reached
   always @(posedge clk_sys_i)
   begin
      clear_o <= hold_bit_i && master_on_i && cnt == delay_i;
      cnt <= hold_bit_i && master_on_i && cnt != delay_i ? cnt + 8'h01
         : 8'h00;
   end
endmodule : board_partner

// File: tb.sv
// Self-checking bench for the system pin control block.
// Assumes the board model drives reset pin, straps and hold clear.
`timescale 1ns/1ps
module tb;
   logic clk = 1'h0, rst_n = 1'h0, aux_n = 1'h1, dir = 1'h0, wreq = 1'h0;
   logic ext_n = 1'h1, up_wr = 1'h0, up_d = 1'h0;
   logic [2:0] dn_wr = 3'h0, dn_d = 3'h0;
   logic [7:0] dly = 8'h00;
   logic fr_n, hreq, ups, dns, clr, crst_n, lrst, run, ee, rsv, hb, upo;
   logic aux_en, woe, wdet, wire_n, sme, wdrv;
   logic [2:0] mode, dno;
   logic [7:0] exp_q[$];
   int fail_count = 0, check_count = 0, seed = 32'h1afe;
   always #50 clk = ~clk;
   assign wire_n = woe ? wdrv : ext_n;
   system_pin_reset_config i_system_pin_reset_config
   (
      .clk_sys_i(clk), .reset_n_i(rst_n), .fundamental_reset_n_i(fr_n),
      .reset_hold_request_i(hreq), .switch_mode_strap_i(mode),
      .common_clock_upstream_strap_i(ups),
      .common_clock_downstream_strap_i(dns),
      .aux_power_disable_n_i(aux_n), .wake_pin_n_i(wire_n),
      .wake_direction_bit_i(dir), .wake_request_i(wreq),
      .hold_bit_clear_i(clr), .up_slot_clock_write_i(up_wr),
      .up_slot_clock_data_i(up_d), .down_slot_clock_write_i(dn_wr),
      .down_slot_clock_data_i(dn_d), .core_reset_n_o(crst_n),
      .link_reset_o(lrst), .serial_master_enable_o(sme),
      .switch_run_o(run), .eeprom_init_o(ee), .mode_reserved_o(rsv),
      .hold_bit_o(hb), .up_slot_clock_o(upo), .down_slot_clock_o(dno),
      .aux_power_enable_o(aux_en), .wake_pin_n_o(wdrv),
      .wake_pin_n_oe_o(woe), .wake_detected_o(wdet)
   );
   board_partner i_board_partner
   (
      .clk_sys_i(clk), .hold_bit_i(hb), .master_on_i(sme), .delay_i(dly),
      .fund_n_o(fr_n),
      .hold_req_o(hreq), .mode_o(mode), .up_o(ups), .dn_o(dns),
      .clear_o(clr)
   );
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      check_count++;
      if (seen !== want)
      begin
         fail_count++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   task automatic hop(input int n);
      repeat (n) @(posedge clk);
   endtask : hop
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
      if (rst_n && $fell(lrst))
      begin
         check({run, ee, rsv, hb, upo, dno}, exp_q.pop_front());
         check({6'h0, sme, aux_en}, 8'h03);
      end
   initial
   begin
      logic [2:0] m, w;
      logic h, u, d;
      int n;
      hop(6);
      rst_n <= 1'h1;
      for (int i = 0; i < 9; i++)
      begin
         hop(1);
         m = 3'(i % 2);
         {h, u, d} = 3'($random(seed));
         dly <= 8'($random(seed)) & 8'h0f;
         exp_q.push_back({m < 3'h2 && !h, m == 3'h1, m > 3'h1, h, u, {3{d}}});
         i_board_partner.boot(m, h, u, d);
         for (n = 0; n < 500; n++)
         begin
            hop(1);
            if (exp_q.size() == 0 && (m > 3'h1 || crst_n === 1'h1))
               break;
         end
         if (n == 500)
         begin
            fail_count++;
            tally_and_finish();
         end
         if (m < 3'h2)
         begin
            #1 check(8'(run), 8'h01);
            w = 3'($random(seed));
            @(posedge clk);
            up_wr <= 1'h1;
            up_d <= ~u;
            dn_wr <= w;
            dn_d <= ~{3{d}};
            hop(1);
            up_wr <= 1'h0;
            dn_wr <= 3'h0;
            hop(2);
            #1 check({4'h0, upo, dno}, {4'h0, ~u, w ^ {3{d}}});
         end
         $display("test %0d done", i);
      end
      hop(1);
      aux_n <= 1'h0;
      dir <= 1'h1;
      wreq <= 1'h1;
      hop(5);
      #1 check({5'h0, aux_en, woe, wire_n}, 8'h02);
      @(posedge clk);
      dir <= 1'h0;
      ext_n <= 1'h0;
      hop(5);
      #1 check({6'h0, woe, wdet}, 8'h01);
      $display("test pins done");
      tally_and_finish();
   end
endmodule : tb
